// *** rtc_alarm_power_window_calibration_tb_top.sv ***
// Self-checking bench: registers, power windows and calibration over APB
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin checked++; if ((got) !== (exp)) begin num_errors++; \
   $display("mismatch at %0t: got %0h, expected %0h", $time, (got), (exp)); end end
module rtc_alarm_power_window_calibration_tb_top;
   // Bus, events, outputs and bench state
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        rtc_tick, alarm_event, minute_pulse, pwc_pin, sample_window, timer_tick;
   logic        tick_on, pol, powered, pin_in, pin_off;
   logic [1:0]  tcnt;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed, d;
   int          num_errors, checked, power_ups, n, m, k, p;
   int          up [3], lo [3];                // Model of the alarm value bytes
   int          mup [3] = '{'h7f, 'h07, 'h1f}; // Stored upper bits per pointer
   int          mlo [3] = '{'h7f, 'h3f, 'h3f}; // Stored lower bits per pointer
   rtc_pwc_top dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rtc_tick(rtc_tick), .alarm_event(alarm_event), .minute_pulse(minute_pulse),
      .pwc_pin(pwc_pin), .sample_window(sample_window), .timer_tick(timer_tick)
   );
   switched_load load (.pclk(pclk), .pwc_pin(pwc_pin), .active_high(pol),
      .powered(powered), .power_ups(power_ups));
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Source tick every fourth cycle, leaving free cycles for inserted ticks
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tcnt <= 2'h0;
         rtc_tick <= 1'b0;
      end
      else
      begin
         tcnt <= tcnt + 2'h1;
         rtc_tick <= tick_on && (tcnt == 2'h3);
      end
   end
   task automatic end_of_test();
      $display("errors %0d, checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   task automatic bail();
      num_errors++;
      end_of_test();
   endtask : bail
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int c;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      c = 0;
      // Sample pready at each rising edge of the access phase; read data and error only at the edge where it is seen
      do
      begin
         @(posedge pclk);
         c++;
      end
      while (pready !== 1'b1 && c < 20);
      if (pready !== 1'b1) bail();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      `CHK(rd, exp)
      `CHK(err, 1'b0)
   endtask : rdchk
   // Counts settled cycles until the sample window reaches a level
   task automatic wait_sw(input logic v, output int c);
      c = 0;
      #1;
      while (sample_window !== v && c < 200)
      begin
         @(posedge pclk);
         #1;
         c++;
      end
      if (c == 200) bail();
   endtask : wait_sw
   task automatic pulse_alarm();
      @(posedge pclk);
      alarm_event <= 1'b1;
      @(posedge pclk);
      alarm_event <= 1'b0;
   endtask : pulse_alarm
   // Start a window (re: second alarm mid-stability), time both phases
   task automatic run_win(input logic [15:0] ctl, wt, input int re);
      apb(1'b1, 12'h014, {16'h0, wt});
      apb(1'b1, 12'h000, {16'h0, ctl});
      // Load takes the new polarity one cycle before the pin settles to it; power-ups are counted from two edges later
      pol <= ctl[14];
      repeat (2) @(posedge pclk);
      k = power_ups;
      pulse_alarm();
      if (re)
      begin
         repeat (12) @(posedge pclk);
         pulse_alarm();
      end
      wait_sw(1'b1, n);
      pin_in = pwc_pin;
      wait_sw(1'b0, m);
      @(posedge pclk);
      #1;
      pin_off = powered;
   endtask : run_win
   // Minute pulse aligned away from source ticks, then count both tick streams
   task automatic cal_run(input logic [7:0] cal, input int delta);
      int rt, tt;
      apb(1'b1, 12'h018, {24'h0, cal});
      for (int j = 0; j < 4 && tcnt != 2'h0; j++) @(posedge pclk);
      minute_pulse <= 1'b1;
      @(posedge pclk);
      minute_pulse <= 1'b0;
      rt = 0;
      tt = 0;
      // Streams counted one cycle apart, from the cycle the adjustment is loaded
      for (int i = 0; i <= 160; i++)
      begin
         #1;
         if (i < 160) rt += rtc_tick;
         if (i > 0) tt += timer_tick;
         @(posedge pclk);
      end
      `CHK(tt - rt, delta)
   endtask : cal_run
   initial
   begin
      repeat (60000) @(posedge pclk);
      bail();
   end
   initial
   begin
      {psel, penable, pwrite, alarm_event, minute_pulse, tick_on, pol} = 7'h0;
      {presetn, paddr, pwdata} = 45'h0;
      seed = 32'h7d2c;
      num_errors = 0;
      checked = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (p = 0; p < 8; p++) rdchk(12'(p * 4), 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      `CHK(err, 1'b1)
      repeat (4)
      begin
         d = rnd();
         apb(1'b1, 12'h010, d);
         rdchk(12'h010, d & 32'h7f7f);
      end
      // Write enable still clear: gated writes are dropped
      apb(1'b1, 12'h014, 32'h1234);
      rdchk(12'h014, 32'h0);
      apb(1'b1, 12'h004, 32'h100);
      apb(1'b1, 12'h008, 32'h5);
      apb(1'b1, 12'h004, 32'h100);
      rdchk(12'h008, 32'h0);
      apb(1'b1, 12'h000, 32'h1);
      for (p = 2; p >= 0; p--)
      begin
         up[p] = rnd() & 'hff;
         lo[p] = rnd() & 'hff;
         apb(1'b1, 12'h004, 32'(p << 8));
         apb(1'b1, 12'h00c, 32'(lo[p]));
         apb(1'b1, 12'h008, 32'(up[p]));
         rdchk(12'h004, 32'((p > 0 ? p - 1 : 0) << 8));
      end
      for (p = 2; p >= 0; p--)
      begin
         apb(1'b1, 12'h004, 32'(p << 8));
         rdchk(12'h00c, 32'(lo[p] & mlo[p]));
         rdchk(12'h008, 32'(up[p] & mup[p]));
      end
      apb(1'b1, 12'h004, 32'h300);
      rdchk(12'h008, 32'h0);
      rdchk(12'h004, 32'h200);
      tick_on <= 1'b1;
      run_win(16'hc301, 16'h0502, 1);
      `CHK(n >= 15 && n <= 25, 1'b1)
      `CHK(m >= 4 && m <= 12, 1'b1)
      `CHK(pin_in, 1'b1)
      `CHK(pin_off, 1'b0)
      `CHK(power_ups - k, 1)
      run_win(16'h8301, 16'h0002, 0);
      `CHK(n <= 3, 1'b1)
      `CHK(pin_in, 1'b0)
      run_win(16'he301, 16'h0300, 0);
      `CHK(n >= 18 && n <= 26, 1'b1)
      `CHK(m <= 3, 1'b1)
      // All-ones sample length holds the window open with power control off
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b1, 12'h014, 32'hff);
      repeat (3) @(posedge pclk);
      #1;
      `CHK(sample_window, 1'b1)
      cal_run(8'hfe, -8);
      cal_run(8'h03, 12);
      cal_run(8'h00, 0);
      end_of_test();
   end
endmodule : rtc_alarm_power_window_calibration_tb_top
`default_nettype wire

// *** rtc_pwc_cal.sv ***
// Once-per-minute calibration: drops or inserts source ticks on the timer tick
`timescale 1ns/1ps
`default_nettype none
`include "rtc_pwc_defs.svh"
module rtc_pwc_cal (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Source tick, minute strobe, signed calibration value
   input  wire logic       rtc_tick,
   input  wire logic       minute_pulse,
   input  wire logic [7:0] cal_value,
   // Adjusted timer tick and busy flag
   output logic            timer_tick,
   output logic            adjust_busy
);
   logic [9:0] pending;      // Pulses still to drop or add
   logic       negative;     // Sign of the pending adjustment
   logic [9:0] next_pending;
   logic       next_negative;
   logic       next_tick;
   logic [9:0] magnitude;    // |cal| times four

   // Magnitude of the signed value, scaled by four
   always_comb
   begin
      magnitude = cal_value[7] ? {2'b00, 8'(-cal_value)} : {2'b00, cal_value};
      magnitude = magnitude << `CAL_SHIFT;
   end

   // Negative drops ticks, positive fills idle cycles with extra ticks
   always_comb
   begin
      next_pending  = pending;
      next_negative = negative;
      next_tick     = rtc_tick;
      if (pending != `PEND_ZERO)
      begin
         if (negative && rtc_tick)
         begin
            next_tick    = 1'b0;
            next_pending = pending - 10'h001;
         end
         else if (!negative && !rtc_tick)
         begin
            next_tick    = 1'b1;
            next_pending = pending - 10'h001;
         end
      end
      // A new minute reloads; an unfinished remainder is abandoned
      if (minute_pulse)
      begin
         next_pending  = magnitude;
         next_negative = cal_value[7];
      end
   end

   // Registers only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pending     <= `PEND_ZERO;
         negative    <= 1'b0;
         timer_tick  <= 1'b0;
         adjust_busy <= 1'b0;
      end
      else
      begin
         pending     <= next_pending;
         negative    <= next_negative;
         timer_tick  <= next_tick;
         adjust_busy <= (next_pending != `PEND_ZERO);
      end
   end
endmodule : rtc_pwc_cal
`default_nettype wire

// *** rtc_pwc_defs.svh ***
// Register offsets, field positions, masks and reset values of the alarm/power window block
`ifndef RTC_PWC_DEFS_SVH
`define RTC_PWC_DEFS_SVH
// Byte offsets on the APB bus
`define OFS_CONTROL     12'h000
`define OFS_ALARM_CFG   12'h004
`define OFS_WIN_UPPER   12'h008
`define OFS_WIN_LOWER   12'h00c
`define OFS_TIME_MS     12'h010
`define OFS_POWER_WIN   12'h014
`define OFS_CALIB       12'h018
`define OFS_STATUS      12'h01c
// Control register fields
`define CTL_WREN_BIT    0
`define CTL_OUTSEL_HI   9
`define CTL_OUTSEL_LO   8
`define CTL_SPRE_BIT    12
`define CTL_CPRE_BIT    13
`define CTL_POL_BIT     14
`define CTL_EN_BIT      15
`define CTL_MASK        16'hf301
`define OUTSEL_POWER    2'h3
// Alarm pointer field
`define PTR_HI          9
`define PTR_LO          8
`define PTR_ZERO        2'h0
// Implemented bits per byte of each value register
`define MASK_MIN_SEC    8'h7f
`define MASK_MONTH      8'h1f
`define MASK_DAY        8'h3f
`define MASK_WEEKDAY    8'h07
`define MASK_HOURS      8'h3f
// Window timer fields and the sample always-on code
`define STAB_HI         15
`define STAB_LO         8
`define SAMP_HI         7
`define SAMP_LO         0
`define SAMP_ALWAYS     8'hff
`define COUNT_ZERO      8'h00
// Calibration: scale by four, ten bits of pending pulses
`define CAL_SHIFT       2
`define PEND_ZERO       10'h000
`define RESET_16        16'h0000
`define RESET_8         8'h00
`endif

// *** rtc_pwc_pkg.sv ***
// Types shared by the alarm/power window block
package rtc_pwc_pkg;
   // Window sequencer states, one-hot
   typedef enum logic [2:0] {
      WIN_IDLE = 3'h1,
      WIN_STAB = 3'h2,
      WIN_SAMP = 3'h4
   } win_state_t;
endpackage : rtc_pwc_pkg

// *** rtc_pwc_prescale.sv ***
// Power-control clock prescaler: passes the source tick through or halves it
`timescale 1ns/1ps
`default_nettype none
module rtc_pwc_prescale (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Source tick and divide select
   input  wire logic rtc_tick,
   input  wire logic div2,
   // Prescaled tick, one cycle
   output logic      pwc_tick
);
   logic phase;       // Toggles on each source tick
   logic next_phase;
   logic next_tick;

   // Halving takes every second source tick
   always_comb
   begin
      next_phase = phase;
      next_tick  = 1'b0;
      if (rtc_tick)
      begin
         next_phase = ~phase;
         next_tick  = div2 ? phase : 1'b1;
      end
   end

   // Registers only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase    <= 1'b0;
         pwc_tick <= 1'b0;
      end
      else
      begin
         phase    <= next_phase;
         pwc_tick <= next_tick;
      end
   end
endmodule : rtc_pwc_prescale
`default_nettype wire

// *** rtc_pwc_top.sv ***
// Alarm value registers, power-control window timers and calibration behind APB
`timescale 1ns/1ps
`default_nettype none
`include "rtc_pwc_defs.svh"
module rtc_pwc_top (
   // APB clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Real-time clock events
   input  wire logic        rtc_tick,
   input  wire logic        alarm_event,
   input  wire logic        minute_pulse,
   // Outputs
   output logic             pwc_pin,
   output logic             sample_window,
   output logic             timer_tick
);
   // Software state
   logic [15:0] control;        // Enables, polarity, prescalers, output select
   logic [15:0] alarm_cfg;      // Pointer in bits 9-8
   logic [15:0] time_ms;        // Minutes/seconds value
   logic [15:0] alarm_md;       // Alarm month/day
   logic [15:0] alarm_wh;       // Alarm weekday/hours
   logic [15:0] alarm_ms;       // Alarm minutes/seconds
   logic [15:0] power_win;      // Stability and sample lengths
   logic [7:0]  calib;          // Signed calibration value
   logic [15:0] next_control, next_alarm_cfg, next_time_ms;
   logic [15:0] next_alarm_md, next_alarm_wh, next_alarm_ms, next_power_win;
   logic [7:0]  next_calib;
   logic [31:0] next_prdata;
   logic        next_pready, next_pslverr;
   // Bus decode helpers
   logic        setup, commit, hit, wren;
   logic [1:0]  ptr;
   logic [7:0]  wbyte;
   // Window sequencer
   rtc_pwc_pkg::win_state_t state, next_state;
   logic [7:0]  count, next_count;
   logic        next_pin, next_sample;
   logic        stab_tick, samp_tick, adjust_busy;
   logic [7:0]  stab_len, samp_len;
   logic        pwc_active;

   assign setup    = psel && !penable;
   assign commit   = psel && penable && pready;
   assign wren     = control[`CTL_WREN_BIT];
   assign ptr      = alarm_cfg[`PTR_HI:`PTR_LO];
   assign wbyte    = pwdata[7:0];
   assign stab_len = power_win[`STAB_HI:`STAB_LO];
   assign samp_len = power_win[`SAMP_HI:`SAMP_LO];

   // Stability and sample clocks each have their own divider
   rtc_pwc_prescale u_stab_pre (
      .pclk     (pclk),
      .presetn  (presetn),
      .rtc_tick (rtc_tick),
      .div2     (control[`CTL_CPRE_BIT]),
      .pwc_tick (stab_tick)
   );
   rtc_pwc_prescale u_samp_pre (
      .pclk     (pclk),
      .presetn  (presetn),
      .rtc_tick (rtc_tick),
      .div2     (control[`CTL_SPRE_BIT]),
      .pwc_tick (samp_tick)
   );

   // Calibration adjusts the timer tick and never touches the registers
   rtc_pwc_cal u_cal (
      .pclk         (pclk),
      .presetn      (presetn),
      .rtc_tick     (rtc_tick),
      .minute_pulse (minute_pulse),
      .cal_value    (calib),
      .timer_tick   (timer_tick),
      .adjust_busy  (adjust_busy)
   );

   // Address decode and read mux; read data is captured in the setup cycle
   always_comb
   begin
      hit         = 1'b1;
      next_prdata = 32'h0000_0000;
      case (paddr)
         `OFS_CONTROL:   next_prdata[15:0] = control;
         `OFS_ALARM_CFG: next_prdata[15:0] = alarm_cfg;
         `OFS_WIN_UPPER, `OFS_WIN_LOWER:
         begin
            // Pointer 11 selects nothing and reads zero
            case (ptr)
               2'h0:    next_prdata[15:0] = alarm_ms;
               2'h1:    next_prdata[15:0] = alarm_wh;
               2'h2:    next_prdata[15:0] = alarm_md;
               default: next_prdata[15:0] = `RESET_16;
            endcase
            if (paddr == `OFS_WIN_UPPER)
               next_prdata[7:0]  = next_prdata[15:8];
            next_prdata[15:8] = 8'h00;
         end
         `OFS_TIME_MS:   next_prdata[15:0] = time_ms;
         `OFS_POWER_WIN: next_prdata[15:0] = power_win;
         `OFS_CALIB:     next_prdata[7:0]  = calib;
         `OFS_STATUS:    next_prdata[3:0]  = {adjust_busy, pwc_active,
                                              state == rtc_pwc_pkg::WIN_SAMP,
                                              state == rtc_pwc_pkg::WIN_STAB};
         default:        hit = 1'b0;
      endcase
      // No wait state: pready rises in the first access cycle
      next_pready  = setup;
      next_pslverr = setup && !hit;
      if (!setup)
         next_prdata = prdata;
   end

   // Register writes at the completing edge only
   always_comb
   begin
      next_control   = control;
      next_alarm_cfg = alarm_cfg;
      next_time_ms   = time_ms;
      next_alarm_md  = alarm_md;
      next_alarm_wh  = alarm_wh;
      next_alarm_ms  = alarm_ms;
      next_power_win = power_win;
      next_calib     = calib;
      if (commit && pwrite)
      begin
         case (paddr)
            `OFS_CONTROL:   next_control   = pwdata[15:0] & `CTL_MASK;
            `OFS_ALARM_CFG: next_alarm_cfg = pwdata[15:0];
            `OFS_TIME_MS:   next_time_ms   = {1'b0, pwdata[14:8], 1'b0, pwdata[6:0]};
            `OFS_POWER_WIN:
               if (wren)
                  next_power_win = pwdata[15:0];
            `OFS_CALIB:     next_calib     = pwdata[7:0];
            `OFS_WIN_UPPER:
               case (ptr)
                  2'h0: next_alarm_ms[15:8] = wbyte & `MASK_MIN_SEC;
                  2'h1:
                     if (wren)
                        next_alarm_wh[15:8] = wbyte & `MASK_WEEKDAY;
                  2'h2:
                     if (wren)
                        next_alarm_md[15:8] = wbyte & `MASK_MONTH;
                  default: ;
               endcase
            `OFS_WIN_LOWER:
               case (ptr)
                  2'h0: next_alarm_ms[7:0] = wbyte & `MASK_MIN_SEC;
                  2'h1:
                     if (wren)
                        next_alarm_wh[7:0] = wbyte & `MASK_HOURS;
                  2'h2:
                     if (wren)
                        next_alarm_md[7:0] = wbyte & `MASK_DAY;
                  default: ;
               endcase
            default: ;
         endcase
      end
      // Any upper-half access steps the pointer down, stopping at zero
      if (commit && paddr == `OFS_WIN_UPPER && ptr != `PTR_ZERO)
         next_alarm_cfg[`PTR_HI:`PTR_LO] = ptr - 2'h1;
   end

   // Window sequencer; an alarm always wins over the running count
   always_comb
   begin
      next_state = state;
      next_count = count;
      case (state)
         rtc_pwc_pkg::WIN_IDLE: ;
         rtc_pwc_pkg::WIN_STAB:
            if (count == `COUNT_ZERO)
            begin
               // Zero sample length still passes through one sample cycle
               next_state = rtc_pwc_pkg::WIN_SAMP;
               next_count = samp_len;
            end
            else if (stab_tick)
               next_count = count - 8'h01;
         rtc_pwc_pkg::WIN_SAMP:
            if (count == `COUNT_ZERO && samp_len != `SAMP_ALWAYS)
               next_state = rtc_pwc_pkg::WIN_IDLE;
            else if (samp_tick && count != `COUNT_ZERO)
               next_count = count - 8'h01;
         default:
         begin
            next_state = rtc_pwc_pkg::WIN_IDLE;
            next_count = `COUNT_ZERO;
         end
      endcase
      if (alarm_event && control[`CTL_EN_BIT])
      begin
         // Restart from every alarm; zero stability goes straight to sampling
         if (stab_len == `COUNT_ZERO)
         begin
            next_state = rtc_pwc_pkg::WIN_SAMP;
            next_count = samp_len;
         end
         else
         begin
            next_state = rtc_pwc_pkg::WIN_STAB;
            next_count = stab_len;
         end
      end
      // Disabling power control abandons a window in progress
      if (!control[`CTL_EN_BIT])
         next_state = rtc_pwc_pkg::WIN_IDLE;
   end

   // Output levels follow the next state so the pins change with it
   always_comb
   begin
      next_sample = (next_state == rtc_pwc_pkg::WIN_SAMP) ||
                    (samp_len == `SAMP_ALWAYS);
      next_pin    = (next_state != rtc_pwc_pkg::WIN_IDLE) &&
                    (control[`CTL_OUTSEL_HI:`CTL_OUTSEL_LO] == `OUTSEL_POWER);
      next_pin    = control[`CTL_POL_BIT] ? next_pin : ~next_pin;
   end

   assign pwc_active = (state != rtc_pwc_pkg::WIN_IDLE);

   // Registers only; value registers clear at reset in place of unknown
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         control       <= `RESET_16;
         alarm_cfg     <= `RESET_16;
         time_ms       <= `RESET_16;
         alarm_md      <= `RESET_16;
         alarm_wh      <= `RESET_16;
         alarm_ms      <= `RESET_16;
         power_win     <= `RESET_16;
         calib         <= `RESET_8;
         prdata        <= 32'h0000_0000;
         pready        <= 1'b0;
         pslverr       <= 1'b0;
         state         <= rtc_pwc_pkg::WIN_IDLE;
         count         <= `COUNT_ZERO;
         pwc_pin       <= 1'b1;
         sample_window <= 1'b0;
      end
      else
      begin
         control       <= next_control;
         alarm_cfg     <= next_alarm_cfg;
         time_ms       <= next_time_ms;
         alarm_md      <= next_alarm_md;
         alarm_wh      <= next_alarm_wh;
         alarm_ms      <= next_alarm_ms;
         power_win     <= next_power_win;
         calib         <= next_calib;
         prdata        <= next_prdata;
         pready        <= next_pready;
         pslverr       <= next_pslverr;
         state         <= next_state;
         count         <= next_count;
         pwc_pin       <= next_pin;
         sample_window <= next_sample;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_alarm_go;
      alarm_event && control[`CTL_EN_BIT];
   endsequence
   sequence s_write_gated;
      commit && pwrite && !wren && paddr == `OFS_POWER_WIN;
   endsequence

   a_unused_bits_zero: assert property (time_ms[15] == 1'b0 && time_ms[7] == 1'b0
      && alarm_md[15:13] == 3'h0 && alarm_wh[15:11] == 5'h00)
      else $error("unused value bits not zero");
   a_write_enable_gate: assert property (s_write_gated |=> $stable(power_win))
      else $error("window register changed without enable");
   a_alarm_restart: assert property (s_alarm_go ##0 (stab_len != `COUNT_ZERO)
      |=> state == rtc_pwc_pkg::WIN_STAB && count == $past(stab_len))
      else $error("alarm did not restart stability window");
   a_zero_stab_sample: assert property (s_alarm_go ##0 (stab_len == `COUNT_ZERO)
      |=> state == rtc_pwc_pkg::WIN_SAMP)
      else $error("zero stability did not start sampling");
   a_stab_to_sample: assert property (!alarm_event && control[`CTL_EN_BIT]
      && state == rtc_pwc_pkg::WIN_STAB && count == `COUNT_ZERO && samp_len != `COUNT_ZERO
      |=> state == rtc_pwc_pkg::WIN_SAMP)
      else $error("sample did not follow stability");
   a_sample_always: assert property (samp_len == `SAMP_ALWAYS |=> sample_window)
      else $error("sample window not held on");
   a_pointer_step: assert property (commit && paddr == `OFS_WIN_UPPER
      && ptr != `PTR_ZERO |=> ptr == $past(ptr) - 2'h1)
      else $error("pointer did not decrement");
   a_pointer_floor: assert property (commit && paddr == `OFS_WIN_UPPER
      && ptr == `PTR_ZERO |=> ptr == `PTR_ZERO)
      else $error("pointer moved below zero");
   a_pin_polarity: assert property (state == rtc_pwc_pkg::WIN_IDLE
      && !(alarm_event && control[`CTL_EN_BIT]) |=> pwc_pin == !$past(control[`CTL_POL_BIT]))
      else $error("idle pin level wrong for polarity");
   a_stab_count_down: assert property (!alarm_event && state == rtc_pwc_pkg::WIN_STAB
      && count != `COUNT_ZERO && stab_tick && control[`CTL_EN_BIT]
      |=> count == $past(count) - 8'h01)
      else $error("stability count did not step");
endmodule : rtc_pwc_top
`default_nettype wire

// *** switched_load.sv ***
// Model of the external load switched by the power-control pin
`timescale 1ns/1ps
`default_nettype none
module switched_load (
   // Clock
   input  wire logic pclk,
   // Switch pin and the level that turns the load on
   input  wire logic pwc_pin,
   input  wire logic active_high,
   // Supply state and count of power-ups
   output logic      powered,
   output int        power_ups
);
   logic was_on = 1'b0; // Supply state one cycle ago
   int   ups    = 0;    // Power-ups seen so far
   // Load is on only while the pin sits at its active level
   assign powered = (pwc_pin === active_high);
   assign power_ups = ups;
   // Count power-ups: a pin that glitches shows up as extra ones
   always @(posedge pclk)
   begin
      was_on <= powered;
      if (powered && !was_on)
         ups <= ups + 1;
   end
endmodule : switched_load
`default_nettype wire
